/* common/obt_defs.svh */
// Constants for the observe-only boundary scan test port.
// Assumes inclusion by bare name from the package and the design file.
`ifndef OBT_DEFS_SVH
`define OBT_DEFS_SVH
`define OBT_IR_LEN 4
`define OBT_IR_RESET 4'h1
`define OBT_OP_EXTEST 4'h0
`define OBT_OP_IDCODE 4'h1
`define OBT_OP_SAMPLE 4'h2
`define OBT_OP_BYPASS 4'hf
`define OBT_ID_LEN 32
`define OBT_ID_VALUE 32'h1234_5001 // Arbitrary identification word; bit 0 stays set as the scan convention asks.
`define OBT_BSR_LEN 16
`define OBT_IR_CAPTURE 4'h1
`endif

/* common/obt_pkg.sv */
// Types for the observe-only boundary scan test port.
// Assumes obt_defs.svh is on the include path.
`include "obt_defs.svh"
package obt_pkg;
    // Test access port states.
    typedef enum logic [3:0] {
        OBT_RESET = 4'h0,
        OBT_IDLE = 4'h1,
        OBT_SEL_DR = 4'h3,
        OBT_CAP_DR = 4'h2,
        OBT_SH_DR = 4'h6,
        OBT_EX1_DR = 4'h7,
        OBT_PA_DR = 4'h5,
        OBT_EX2_DR = 4'h4,
        OBT_UP_DR = 4'hc,
        OBT_SEL_IR = 4'hd,
        OBT_CAP_IR = 4'hf,
        OBT_SH_IR = 4'he,
        OBT_EX1_IR = 4'ha,
        OBT_PA_IR = 4'hb,
        OBT_EX2_IR = 4'h9,
        OBT_UP_IR = 4'h8
    } obt_state_t;
endpackage : obt_pkg

/* hdl/obt_tap.sv */
// Observe-only boundary scan test access port with identification readout.
// Assumes the test master drives tck_i, tms_i and tdi_i; pins_i are device pin levels.
`timescale 1ns/1ns
`default_nettype none
`include "obt_defs.svh"

module obt_tap (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic [`OBT_BSR_LEN-1:0] pins_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    output logic [`OBT_IR_LEN-1:0] ir_o
);
    // Power-on reset for the scan logic: asserted at once, released on the test clock.
    // There is no test reset pin, so once running only resetn_i low or five high mode clocks reset the port.
    logic tck_rstn_meta_reg;
    logic tck_rstn_reg;
    always_ff @(posedge tck_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tck_rstn_meta_reg <= 1'b0;
            tck_rstn_reg <= 1'b0;
        end else begin
            tck_rstn_meta_reg <= 1'b1;
            tck_rstn_reg <= tck_rstn_meta_reg;
        end
    end

    // Instruction decode, shared by capture, shift, output selection and the checks.
    function automatic logic sel_id(input logic [`OBT_IR_LEN-1:0] op);
        sel_id = (op == `OBT_OP_IDCODE);
    endfunction : sel_id

    // Both pin instructions only observe; no instruction can reach a pin from here.
    function automatic logic sel_bsr(input logic [`OBT_IR_LEN-1:0] op);
        sel_bsr = (op == `OBT_OP_SAMPLE) || (op == `OBT_OP_EXTEST);
    endfunction : sel_bsr

    obt_pkg::obt_state_t state_reg;
    obt_pkg::obt_state_t state_next;
    logic capture_dr;
    logic shift_dr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;
    logic [`OBT_IR_LEN-1:0] ir_shift_reg;
    logic [`OBT_IR_LEN-1:0] ir_reg;
    logic [`OBT_IR_LEN-1:0] ir_next;
    logic ir_tgl_reg;
    logic [`OBT_ID_LEN-1:0] id_shift_reg;
    logic bypass_reg;
    logic [`OBT_BSR_LEN-1:0] pin_meta_reg;
    logic [`OBT_BSR_LEN-1:0] pin_sync_reg;
    logic [`OBT_BSR_LEN-1:0] bsr_reg;
    logic tdo_next;
    logic ir_tgl_meta_reg;
    logic ir_tgl_sync_reg;
    logic ir_tgl_seen_reg;

    // Next state of the access port; every code is a real state, so no default.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            obt_pkg::OBT_RESET: state_next = tms_i ? obt_pkg::OBT_RESET : obt_pkg::OBT_IDLE;
            obt_pkg::OBT_IDLE: state_next = tms_i ? obt_pkg::OBT_SEL_DR : obt_pkg::OBT_IDLE;
            obt_pkg::OBT_SEL_DR: state_next = tms_i ? obt_pkg::OBT_SEL_IR : obt_pkg::OBT_CAP_DR;
            obt_pkg::OBT_CAP_DR: state_next = tms_i ? obt_pkg::OBT_EX1_DR : obt_pkg::OBT_SH_DR;
            obt_pkg::OBT_SH_DR: state_next = tms_i ? obt_pkg::OBT_EX1_DR : obt_pkg::OBT_SH_DR;
            obt_pkg::OBT_EX1_DR: state_next = tms_i ? obt_pkg::OBT_UP_DR : obt_pkg::OBT_PA_DR;
            obt_pkg::OBT_PA_DR: state_next = tms_i ? obt_pkg::OBT_EX2_DR : obt_pkg::OBT_PA_DR;
            obt_pkg::OBT_EX2_DR: state_next = tms_i ? obt_pkg::OBT_UP_DR : obt_pkg::OBT_SH_DR;
            obt_pkg::OBT_UP_DR: state_next = tms_i ? obt_pkg::OBT_SEL_DR : obt_pkg::OBT_IDLE;
            obt_pkg::OBT_SEL_IR: state_next = tms_i ? obt_pkg::OBT_RESET : obt_pkg::OBT_CAP_IR;
            obt_pkg::OBT_CAP_IR: state_next = tms_i ? obt_pkg::OBT_EX1_IR : obt_pkg::OBT_SH_IR;
            obt_pkg::OBT_SH_IR: state_next = tms_i ? obt_pkg::OBT_EX1_IR : obt_pkg::OBT_SH_IR;
            obt_pkg::OBT_EX1_IR: state_next = tms_i ? obt_pkg::OBT_UP_IR : obt_pkg::OBT_PA_IR;
            obt_pkg::OBT_PA_IR: state_next = tms_i ? obt_pkg::OBT_EX2_IR : obt_pkg::OBT_PA_IR;
            obt_pkg::OBT_EX2_IR: state_next = tms_i ? obt_pkg::OBT_UP_IR : obt_pkg::OBT_SH_IR;
            obt_pkg::OBT_UP_IR: state_next = tms_i ? obt_pkg::OBT_SEL_DR : obt_pkg::OBT_IDLE;
        endcase
    end

    // State register on the rising test clock.
    always_ff @(posedge tck_i or negedge tck_rstn_reg) begin
        if (!tck_rstn_reg) begin
            state_reg <= obt_pkg::OBT_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Phase strobes decoded once from the state.
    assign capture_dr = (state_reg == obt_pkg::OBT_CAP_DR);
    assign shift_dr = (state_reg == obt_pkg::OBT_SH_DR);
    assign capture_ir = (state_reg == obt_pkg::OBT_CAP_IR);
    assign shift_ir = (state_reg == obt_pkg::OBT_SH_IR);
    assign update_ir = (state_reg == obt_pkg::OBT_UP_IR);

    // Instruction shift stage: fixed capture pattern, then data enters at the top.
    always_ff @(posedge tck_i or negedge tck_rstn_reg) begin
        if (!tck_rstn_reg) begin
            ir_shift_reg <= `OBT_IR_CAPTURE;
        end else if (capture_ir) begin
            ir_shift_reg <= `OBT_IR_CAPTURE;
        end else if (shift_ir) begin
            ir_shift_reg <= {tdi_i, ir_shift_reg[`OBT_IR_LEN-1:1]};
        end
    end

    // Held instruction: identification after reset, the shifted word on update.
    always_comb begin
        ir_next = ir_reg;
        if (state_reg == obt_pkg::OBT_RESET) begin
            ir_next = `OBT_IR_RESET;
        end else if (update_ir) begin
            ir_next = ir_shift_reg;
        end
    end

    always_ff @(posedge tck_i or negedge tck_rstn_reg) begin
        if (!tck_rstn_reg) begin
            ir_reg <= `OBT_IR_RESET;
        end else begin
            ir_reg <= ir_next;
        end
    end

    // A toggle marks each change of the instruction for the system clock side.
    always_ff @(posedge tck_i or negedge tck_rstn_reg) begin
        if (!tck_rstn_reg) begin
            ir_tgl_reg <= 1'b0;
        end else if (ir_next != ir_reg) begin
            ir_tgl_reg <= ~ir_tgl_reg;
        end
    end

    // Identification register, shifted out least significant bit first.
    always_ff @(posedge tck_i or negedge tck_rstn_reg) begin
        if (!tck_rstn_reg) begin
            id_shift_reg <= `OBT_ID_VALUE;
        end else if (capture_dr && sel_id(ir_reg)) begin
            id_shift_reg <= `OBT_ID_VALUE;
        end else if (shift_dr && sel_id(ir_reg)) begin
            id_shift_reg <= {tdi_i, id_shift_reg[`OBT_ID_LEN-1:1]};
        end
    end

    // One-bit bypass stage for every other instruction; captures zero.
    always_ff @(posedge tck_i or negedge tck_rstn_reg) begin
        if (!tck_rstn_reg) begin
            bypass_reg <= 1'b0;
        end else if (capture_dr) begin
            bypass_reg <= 1'b0;
        end else if (shift_dr) begin
            bypass_reg <= tdi_i;
        end
    end

    // Observe cells. Each pin passes two flip-flops on the test clock first; pins that
    // move near the capture edge may land in different scans, which is fine for observing.
    genvar gi;
    generate
        for (gi = 0; gi < `OBT_BSR_LEN; gi++) begin : g_cell
            logic shift_in;
            if (gi == `OBT_BSR_LEN - 1) begin : g_last
                assign shift_in = tdi_i;
            end else begin : g_mid
                assign shift_in = bsr_reg[gi+1];
            end
            always_ff @(posedge tck_i or negedge tck_rstn_reg) begin
                if (!tck_rstn_reg) begin
                    pin_meta_reg[gi] <= 1'b0;
                    pin_sync_reg[gi] <= 1'b0;
                    bsr_reg[gi] <= 1'b0;
                end else begin
                    pin_meta_reg[gi] <= pins_i[gi];
                    pin_sync_reg[gi] <= pin_meta_reg[gi];
                    if (capture_dr && sel_bsr(ir_reg)) begin
                        bsr_reg[gi] <= pin_sync_reg[gi];
                    end else if (shift_dr && sel_bsr(ir_reg)) begin
                        bsr_reg[gi] <= shift_in;
                    end
                end
            end
        end
    endgenerate

    // Scan output selection; the instruction stage wins while it is being shifted.
    always_comb begin
        tdo_next = bypass_reg;
        if (shift_ir) begin
            tdo_next = ir_shift_reg[0];
        end else if (sel_id(ir_reg)) begin
            tdo_next = id_shift_reg[0];
        end else if (sel_bsr(ir_reg)) begin
            tdo_next = bsr_reg[0];
        end
    end

    // The scan output and its enable move on the falling test clock, so the master
    // sees a settled bit half a period later at its rising edge. The four scan signals
    // are the whole link; the enable only marks when the output is meaningful.
    always_ff @(negedge tck_i or negedge tck_rstn_reg) begin
        if (!tck_rstn_reg) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else begin
            tdo_o <= tdo_next;
            tdo_oe_o <= shift_dr || shift_ir;
        end
    end

    // Instruction handed to the system clock: the toggle is synchronised, and the word
    // is read on the system clock edge after the synchronised toggle shows a change.
    // Limitation: this relies on at least three system-clock periods between updates.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ir_tgl_meta_reg <= 1'b0;
            ir_tgl_sync_reg <= 1'b0;
            ir_tgl_seen_reg <= 1'b0;
        end else begin
            ir_tgl_meta_reg <= ir_tgl_reg;
            ir_tgl_sync_reg <= ir_tgl_meta_reg;
            ir_tgl_seen_reg <= ir_tgl_sync_reg;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ir_o <= `OBT_IR_RESET;
        end else if (ir_tgl_sync_reg != ir_tgl_seen_reg) begin
            ir_o <= ir_reg;
        end
    end

    // Checks on the test clock side.
    sequence s_mode_high_five;
        tms_i [*5];
    endsequence

    sequence s_idle_to_select;
        (state_reg == obt_pkg::OBT_IDLE && tms_i) ##1 !tms_i;
    endsequence

    property p_mode_reset;
        @(posedge tck_i) disable iff (!tck_rstn_reg)
        s_mode_high_five |=> (state_reg == obt_pkg::OBT_RESET);
    endproperty
    a_mode_reset: assert property (p_mode_reset)
        else $error("five high mode clocks did not reach reset");

    property p_reset_ir;
        @(posedge tck_i) disable iff (!tck_rstn_reg)
        (state_reg == obt_pkg::OBT_RESET) |=> (ir_reg == `OBT_IR_RESET);
    endproperty
    a_reset_ir: assert property (p_reset_ir)
        else $error("reset state did not select identification");

    property p_enter_capture_dr;
        @(posedge tck_i) disable iff (!tck_rstn_reg)
        s_idle_to_select |=> (state_reg == obt_pkg::OBT_CAP_DR);
    endproperty
    a_enter_capture_dr: assert property (p_enter_capture_dr)
        else $error("high then low mode from idle did not reach data capture");

    property p_oe_shift;
        @(posedge tck_i) disable iff (!tck_rstn_reg)
        tdo_oe_o == (shift_dr || shift_ir);
    endproperty
    a_oe_shift: assert property (p_oe_shift)
        else $error("scan output enable does not follow the shift states");

    property p_tdo_lsb;
        @(posedge tck_i) disable iff (!tck_rstn_reg)
        (shift_dr && sel_id(ir_reg)) |-> (tdo_o == id_shift_reg[0]);
    endproperty
    a_tdo_lsb: assert property (p_tdo_lsb)
        else $error("scan output is not the low identification bit");

    property p_id_capture;
        @(posedge tck_i) disable iff (!tck_rstn_reg)
        (capture_dr && sel_id(ir_reg)) |=> (id_shift_reg == `OBT_ID_VALUE);
    endproperty
    a_id_capture: assert property (p_id_capture)
        else $error("identification word not captured");

    property p_bsr_capture;
        @(posedge tck_i) disable iff (!tck_rstn_reg)
        (capture_dr && sel_bsr(ir_reg)) |=> (bsr_reg == $past(pin_sync_reg));
    endproperty
    a_bsr_capture: assert property (p_bsr_capture)
        else $error("observe cells did not capture the pin levels");

    property p_ir_capture;
        @(posedge tck_i) disable iff (!tck_rstn_reg)
        capture_ir |=> (ir_shift_reg == `OBT_IR_CAPTURE);
    endproperty
    a_ir_capture: assert property (p_ir_capture)
        else $error("instruction capture pattern missing");
endmodule : obt_tap
`default_nettype wire

/* sim/obt_master.sv */
// Test master model: clocks single scan bits and walks the mode-only reset.
// Assumes the bench calls its tasks one at a time; the test clock stands still between calls.
`timescale 1ns/1ns
`default_nettype none
module obt_master (
    output var logic tck_o,
    output var logic tms_o,
    output var logic tdi_o,
    input wire logic tdo_i
);
    // Idle levels: clock low, mode high so a stray clock heads for reset.
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    // One test-clock period of 48 ns. Mode and data change while the clock is low;
    // the scan output is taken at the rise, half a period after the port moved it.
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #24 tck_o = 1'b1;
        tdo = tdo_i;
        #24 tck_o = 1'b0;
    endtask : step

    // Six clocks with mode high before any scan work; ends in the reset state.
    task automatic mode_reset;
        logic b;
        repeat (6) step(1'b1, 1'b0, b);
    endtask : mode_reset
endmodule : obt_master
`default_nettype wire

/* sim/tb.sv */
// Bench: reads the identification word after the mode-only reset.
// Assumes obt_defs.svh is on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "obt_defs.svh"
module tb;
    logic clk_i = 1'b0;
    logic resetn_i;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic [15:0] pins = 16'h0000;
    logic [3:0] ir;
    int cycles = 0;
    int mismatches = 0;
    int compares = 0;

    obt_master obt_master_inst (
        .tck_o(tck),
        .tms_o(tms),
        .tdi_o(tdi),
        .tdo_i(tdo)
    );

    obt_tap obt_tap_inst (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .tck_i(tck),
        .tms_i(tms),
        .tdi_i(tdi),
        .pins_i(pins),
        .tdo_o(tdo),
        .tdo_oe_o(tdo_oe),
        .ir_o(ir)
    );

    // The one comparison point of the bench.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // Lets the instruction toggle cross, then samples away from the launching edge.
    task automatic wait_clk;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
    endtask : wait_clk

    // From idle: load an instruction and return the bits the instruction stage captured.
    task automatic load_ir(input logic [3:0] op, output logic [3:0] cap);
        logic b;
        int i;
        obt_master_inst.step(1'b1, 1'b0, b);
        obt_master_inst.step(1'b1, 1'b0, b);
        obt_master_inst.step(1'b0, 1'b0, b);
        obt_master_inst.step(1'b0, 1'b0, b);
        for (i = 0; i < 4; i++) begin
            obt_master_inst.step(i == 3, op[i], b);
            cap[i] = b;
        end
        obt_master_inst.step(1'b1, 1'b0, b);
        obt_master_inst.step(1'b0, 1'b0, b);
    endtask : load_ir

    // From idle: shift n data bits, first bit out first, and return to idle.
    task automatic scan_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic b;
        int i;
        dout = 32'h0000_0000;
        obt_master_inst.step(1'b1, 1'b0, b);
        obt_master_inst.step(1'b0, 1'b0, b);
        obt_master_inst.step(1'b0, 1'b0, b);
        for (i = 0; i < n; i++) begin
            obt_master_inst.step(i == n - 1, din[i], b);
            dout[i] = b;
            if (i == 0) begin
                #10 chk("tdo_oe_shift", tdo_oe, 1'b1);
            end
        end
        obt_master_inst.step(1'b1, 1'b0, b);
        obt_master_inst.step(1'b0, 1'b0, b);
        #10 chk("tdo_oe_idle", tdo_oe, 1'b0);
    endtask : scan_dr

    task automatic test_idcode;
        logic b;
        logic [31:0] got;
        obt_master_inst.mode_reset;
        obt_master_inst.step(1'b0, 1'b0, b);
        scan_dr(32, 32'h0000_0000, got);
        chk("idcode", got, `OBT_ID_VALUE);
        wait_clk;
        chk("ir_after_reset", ir, `OBT_IR_RESET);
        $display("idcode test done");
    endtask : test_idcode

    task automatic test_bypass;
        logic [3:0] cap;
        logic [31:0] got;
        load_ir(`OBT_OP_BYPASS, cap);
        chk("ir_capture", cap, `OBT_IR_CAPTURE);
        wait_clk;
        chk("ir_bypass", ir, `OBT_OP_BYPASS);
        scan_dr(8, 32'h0000_00b6, got);
        chk("bypass", got, 32'h0000_006c);
        $display("bypass test done");
    endtask : test_bypass

    task automatic test_observe(input logic [3:0] op, input logic [15:0] val);
        logic [3:0] cap;
        logic [31:0] got;
        @(posedge clk_i);
        pins <= val;
        load_ir(op, cap);
        chk("ir_capture", cap, `OBT_IR_CAPTURE);
        wait_clk;
        chk("ir_observe", ir, op);
        scan_dr(16, 32'h0000_0000, got);
        chk("pins", got, {16'h0000, val});
        $display("observe test done");
    endtask : test_observe

    task automatic test_mode_reset;
        logic b;
        logic [3:0] cap;
        logic [31:0] got;
        load_ir(`OBT_OP_BYPASS, cap);
        obt_master_inst.mode_reset;
        obt_master_inst.step(1'b0, 1'b0, b);
        wait_clk;
        chk("ir_mode_reset", ir, `OBT_IR_RESET);
        scan_dr(32, 32'h0000_0000, got);
        chk("idcode_again", got, `OBT_ID_VALUE);
        $display("mode reset test done");
    endtask : test_mode_reset

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // The whole run needs well under a thousand system clocks.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            summarize;
        end
    end

    initial begin
        resetn_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        test_idcode;
        test_bypass;
        test_observe(`OBT_OP_SAMPLE, 16'ha5c3);
        test_observe(`OBT_OP_EXTEST, 16'h3c5a);
        test_mode_reset;
        summarize;
    end
endmodule : tb
`default_nettype wire
